// *** src/charge_phase_sequencer.sv ***
// Charge phase sequencer: phases, current setpoint, safety timers, status pins.
// Assumes comparator flags and select pins are asynchronous to aclk, and a
// periodic timebase tick from logic on aclk.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.

// What this block does
// - Battery below precharge threshold of 3 V counts as deeply discharged.
// - Precharge commands ten percent of the selected fast-charge current.
// - Battery above threshold at charge start skips precharge, goes fast-charge.
// - Supply select low picks adapter mode; only adapter current setting used.
// - Supply select high picks USB mode; only USB current setting used.
// - Battery reaching precharge threshold moves precharge into fast-charge.
// - USB with power-level high uses full USB programmed current.
// - USB with power-level low uses one fifth of high-power current.
// - Battery near 4.2 V moves fast-charge into voltage regulation.
// - Current below termination for deglitch time ends charge, signals done.
// - Deglitch interval is maximum charge time divided by 220.
// - From done, battery below 4.05 V recharge threshold restarts charging.
// - Maximum charge timer starts at beginning of fast-charge.
// - Maximum charge timer expiry before end of charge raises a fault.
// - Precharge limited to one eighth max time; expiry below threshold faults.
// - Low-power USB stretches max time and derived timers five times.
// - Status pins: charging a on, done b on, fault both on.
module charge_phase_sequencer #(
  parameter int unsigned MAX_CHARGE_TICKS = 32'h0030_5700
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          timebase_tick,
  input  wire charge_pkg::comp_t             comp_in,
  input  wire logic                          supply_usb_select,
  input  wire logic                          usb_power_level_select,
  output logic [charge_pkg::CUR_W-1:0]       charge_current_setpoint,
  output charge_pkg::phase_t                 phase_code,
  output charge_pkg::led_t                   status_pins,
  output logic                               irq,
  // AXI4-Lite slave
  input  wire logic [charge_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [charge_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [charge_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [charge_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);

  localparam int unsigned CW = 40;
  localparam int unsigned EW = charge_pkg::EV_W;
  localparam int unsigned CUR_W = charge_pkg::CUR_W;

  // Two-flop synchronisers for analog flags and pins
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {comp_in, supply_usb_select, usb_power_level_select};
      sync2_reg <= sync1_reg;
    end
  end
  logic bat_low;
  logic bat_near;
  logic bat_rchg;
  logic cur_low;
  logic usb_mode;
  logic usb_high;
  assign {bat_low, bat_near, bat_rchg, cur_low, usb_mode, usb_high} = sync2_reg;

  // Software registers
  logic            enable_reg;
  logic [15:0]     adapter_reg;
  logic [15:0]     usb_reg;
  logic [EW-1:0]   irq_stat_reg;
  logic [EW-1:0]   irq_mask_reg;
  logic [EW-1:0]   events;

  // Fast-charge current selection
  logic [CUR_W-1:0] fast_current;
  logic             low_power;
  assign low_power = usb_mode && !usb_high;
  always_comb begin
    if (!usb_mode) begin
      fast_current = adapter_reg;
    end else if (usb_high) begin
      fast_current = usb_reg;
    end else begin
      fast_current = CUR_W'(usb_reg / charge_pkg::LOW_POWER_DIV);
    end
  end

  // Timer limits, scaled from the one parameter
  logic [CW-1:0] max_limit;
  logic [CW-1:0] pre_limit;
  logic [CW-1:0] deg_limit;
  always_comb begin
    max_limit = CW'(MAX_CHARGE_TICKS);
    if (low_power) begin
      max_limit = CW'(MAX_CHARGE_TICKS) * CW'(charge_pkg::LOW_POWER_DIV);
    end
    pre_limit = max_limit / CW'(charge_pkg::PRECH_TIME_DIV);
    deg_limit = max_limit / CW'(charge_pkg::DEGLITCH_DIV);
  end

  // Phase machine and timers
  charge_pkg::phase_t phase_reg;
  charge_pkg::phase_t phase_next;
  logic [CW-1:0]      pre_cnt_reg;
  logic [CW-1:0]      max_cnt_reg;
  logic [CW-1:0]      deg_cnt_reg;
  logic               pre_expired;
  logic               max_expired;
  logic               deg_expired;
  assign pre_expired = timebase_tick && (pre_cnt_reg + 1'b1 >= pre_limit);
  assign max_expired = timebase_tick && (max_cnt_reg + 1'b1 >= max_limit);
  assign deg_expired = timebase_tick && (deg_cnt_reg + 1'b1 >= deg_limit);

  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      charge_pkg::PH_IDLE: begin
        if (enable_reg) begin
          phase_next = bat_low ? charge_pkg::PH_PRE : charge_pkg::PH_FAST;
        end
      end
      charge_pkg::PH_PRE: begin
        if (!bat_low) begin
          phase_next = charge_pkg::PH_FAST;
        end else if (pre_expired) begin
          phase_next = charge_pkg::PH_FAULT;
        end
      end
      charge_pkg::PH_FAST: begin
        if (max_expired) begin
          phase_next = charge_pkg::PH_FAULT;
        end else if (bat_near) begin
          phase_next = charge_pkg::PH_VREG;
        end
      end
      charge_pkg::PH_VREG: begin
        if (cur_low && deg_expired) begin
          phase_next = charge_pkg::PH_DONE;
        end else if (max_expired) begin
          phase_next = charge_pkg::PH_FAULT;
        end
      end
      charge_pkg::PH_DONE: begin
        if (bat_rchg) begin
          phase_next = charge_pkg::PH_FAST;
        end
      end
      charge_pkg::PH_FAULT: begin
        phase_next = charge_pkg::PH_FAULT;
      end
      default: begin
        phase_next = charge_pkg::PH_IDLE;
      end
    endcase
    // Disabling is the only way out of a fault; it restarts from idle.
    if (!enable_reg) begin
      phase_next = charge_pkg::PH_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= charge_pkg::PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Precharge timer runs only in precharge
  always_ff @(posedge aclk) begin
    if (!aresetn || phase_reg != charge_pkg::PH_PRE) begin
      pre_cnt_reg <= '0;
    end else if (timebase_tick) begin
      pre_cnt_reg <= pre_cnt_reg + 1'b1;
    end
  end

  // Max timer restarts on every entry to fast-charge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      max_cnt_reg <= '0;
    end else if (phase_next == charge_pkg::PH_FAST && phase_reg != charge_pkg::PH_FAST) begin
      max_cnt_reg <= '0;
    end else if (timebase_tick && (phase_reg == charge_pkg::PH_FAST ||
                                   phase_reg == charge_pkg::PH_VREG)) begin
      max_cnt_reg <= max_cnt_reg + 1'b1;
    end
  end

  // Deglitch: any return above threshold restarts the wait
  always_ff @(posedge aclk) begin
    if (!aresetn || phase_reg != charge_pkg::PH_VREG || !cur_low) begin
      deg_cnt_reg <= '0;
    end else if (timebase_tick) begin
      deg_cnt_reg <= deg_cnt_reg + 1'b1;
    end
  end

  // Outputs from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_current_setpoint <= '0;
      phase_code              <= charge_pkg::PH_IDLE;
      status_pins             <= '0;
    end else begin
      phase_code <= phase_reg;
      unique case (phase_reg)
        charge_pkg::PH_PRE: begin
          charge_current_setpoint <= CUR_W'((32'(fast_current) * charge_pkg::PRECH_PCT)
                                            / charge_pkg::PCT_FULL);
          status_pins <= '{status_out_a: 1'b1, status_out_b: 1'b0};
        end
        charge_pkg::PH_FAST, charge_pkg::PH_VREG: begin
          charge_current_setpoint <= fast_current;
          status_pins <= '{status_out_a: 1'b1, status_out_b: 1'b0};
        end
        charge_pkg::PH_DONE: begin
          charge_current_setpoint <= '0;
          status_pins <= '{status_out_a: 1'b0, status_out_b: 1'b1};
        end
        charge_pkg::PH_FAULT: begin
          charge_current_setpoint <= '0;
          status_pins <= '{status_out_a: 1'b1, status_out_b: 1'b1};
        end
        default: begin
          charge_current_setpoint <= '0;
          status_pins <= '0;
        end
      endcase
    end
  end

  // Events for the interrupt status
  always_comb begin
    events = '0;
    events[charge_pkg::EV_FAST_BIT]  = phase_next == charge_pkg::PH_FAST &&
                                       phase_reg == charge_pkg::PH_PRE;
    events[charge_pkg::EV_DONE_BIT]  = phase_next == charge_pkg::PH_DONE &&
                                       phase_reg != charge_pkg::PH_DONE;
    events[charge_pkg::EV_FAULT_BIT] = phase_next == charge_pkg::PH_FAULT &&
                                       phase_reg != charge_pkg::PH_FAULT;
    events[charge_pkg::EV_RECHG_BIT] = phase_next == charge_pkg::PH_FAST &&
                                       phase_reg == charge_pkg::PH_DONE;
  end

  // AXI4-Lite write path: address and data taken in either order
  logic                         aw_held_reg;
  logic                         w_held_reg;
  logic [charge_pkg::ADDR_W-1:0] awaddr_reg;
  logic [charge_pkg::DATA_W-1:0] wdata_reg;
  logic [3:0]                   wstrb_reg;
  logic                         do_write;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= charge_pkg::RESP_OKAY;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (awaddr_reg)
          charge_pkg::OFS_CTRL, charge_pkg::OFS_MASK,
          charge_pkg::OFS_ADAPTER, charge_pkg::OFS_USB: s_axi_bresp <= charge_pkg::RESP_OKAY;
          default:                                      s_axi_bresp <= charge_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg   <= charge_pkg::CTRL_RESET_VAL;
      irq_mask_reg <= '0;
      adapter_reg  <= charge_pkg::ADAPTER_RESET;
      usb_reg      <= charge_pkg::USB_RESET;
    end else if (do_write) begin
      if (awaddr_reg == charge_pkg::OFS_CTRL && wstrb_reg[0]) begin
        enable_reg <= wdata_reg[charge_pkg::CTRL_ENABLE_BIT];
      end
      if (awaddr_reg == charge_pkg::OFS_MASK && wstrb_reg[0]) begin
        irq_mask_reg <= wdata_reg[EW-1:0];
      end
      if (awaddr_reg == charge_pkg::OFS_ADAPTER) begin
        if (wstrb_reg[0]) adapter_reg[7:0]  <= wdata_reg[7:0];
        if (wstrb_reg[1]) adapter_reg[15:8] <= wdata_reg[15:8];
      end
      if (awaddr_reg == charge_pkg::OFS_USB) begin
        if (wstrb_reg[0]) usb_reg[7:0]  <= wdata_reg[7:0];
        if (wstrb_reg[1]) usb_reg[15:8] <= wdata_reg[15:8];
      end
    end
  end

  // AXI4-Lite read path, one cycle after the address is taken
  logic rd_irq_clear;
  assign rd_irq_clear = s_axi_arvalid && s_axi_arready && s_axi_araddr == charge_pkg::OFS_IRQ;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= charge_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= charge_pkg::RESP_OKAY;
        s_axi_rdata   <= '0;
        unique case (s_axi_araddr)
          charge_pkg::OFS_CTRL:    s_axi_rdata[0]       <= enable_reg;
          charge_pkg::OFS_STATUS:  s_axi_rdata[7:0]     <= {low_power, usb_mode, status_pins,
                                                            1'b0, phase_reg};
          charge_pkg::OFS_IRQ:     s_axi_rdata[EW-1:0]  <= irq_stat_reg;
          charge_pkg::OFS_MASK:    s_axi_rdata[EW-1:0]  <= irq_mask_reg;
          charge_pkg::OFS_ADAPTER: s_axi_rdata[15:0]    <= adapter_reg;
          charge_pkg::OFS_USB:     s_axi_rdata[15:0]    <= usb_reg;
          charge_pkg::OFS_SETPT:   s_axi_rdata[15:0]    <= charge_current_setpoint;
          default:                 s_axi_rresp          <= charge_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Sticky events cleared by reading; a same-cycle event survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (rd_irq_clear ? '0 : irq_stat_reg) | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((rd_irq_clear ? '0 : irq_stat_reg) | events) & irq_mask_reg);
    end
  end

endmodule : charge_phase_sequencer

// *** src/charge_pkg.sv ***
// Shared constants, types and register map of the charge phase sequencer.
// Assumes one 100 MHz clock and an AXI4-Lite master for software access.
package charge_pkg;

  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned CUR_W      = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_IRQ     = 8'h08;
  localparam logic [7:0] OFS_MASK    = 8'h0C;
  localparam logic [7:0] OFS_ADAPTER = 8'h10;
  localparam logic [7:0] OFS_USB     = 8'h14;
  localparam logic [7:0] OFS_SETPT   = 8'h18;

  // Control fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic [0:0]  CTRL_RESET_VAL  = 1'b0;

  // Event bits in status and mask registers
  localparam int unsigned EV_W          = 4;
  localparam int unsigned EV_FAST_BIT   = 0;
  localparam int unsigned EV_DONE_BIT   = 1;
  localparam int unsigned EV_FAULT_BIT  = 2;
  localparam int unsigned EV_RECHG_BIT  = 3;

  localparam logic [15:0] ADAPTER_RESET = 16'h01C2;
  localparam logic [15:0] USB_RESET     = 16'h01F4;

  // Scaling of the timers and currents
  localparam int unsigned PRECH_PCT       = 10;
  localparam int unsigned PCT_FULL        = 100;
  localparam int unsigned LOW_POWER_DIV   = 5;
  localparam int unsigned DEGLITCH_DIV    = 220;
  localparam int unsigned PRECH_TIME_DIV  = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_PRE   = 3'b001,
    PH_FAST  = 3'b010,
    PH_VREG  = 3'b011,
    PH_DONE  = 3'b100,
    PH_FAULT = 3'b101
  } phase_t;

  // Comparator flags from the analog path
  typedef struct packed {
    logic below_precharge;   // battery below 3 V
    logic near_regulation;   // battery close to 4.2 V
    logic below_recharge;    // battery below 4.05 V
    logic below_termination; // current below end threshold
  } comp_t;

  // Status pin pair
  typedef struct packed {
    logic status_out_a;
    logic status_out_b;
  } led_t;

endpackage : charge_pkg

// *** tb/charge_partner.sv ***
// Analog path stand-in: battery voltage in mV turned into comparator flags.
// Assumes the bench sets the voltage; current taper is ideal near 4.2 V.
module charge_partner #(
  parameter int unsigned V_PRE  = 3000,
  parameter int unsigned V_NEAR = 4150,
  parameter int unsigned RECHARGE_THRESHOLD  = 4050,
  parameter int unsigned V_TERM = 4200
) (
  input  wire logic        aclk,
  input  wire logic [15:0] bat_mv,
  output charge_pkg::comp_t comp
);
  always_ff @(posedge aclk) begin
    comp.below_precharge   <= bat_mv < V_PRE;
    comp.near_regulation   <= bat_mv >= V_NEAR;
    comp.below_recharge    <= bat_mv < RECHARGE_THRESHOLD;
    comp.below_termination <= bat_mv >= V_TERM;
  end
endmodule : charge_partner

// *** tb/charge_phase_sequencer_tb.sv ***
// Self-checking bench: AXI4-Lite register tasks, read results checked from a queue.
// Assumes the partner model feeds comparator flags from the bench's battery voltage.
module charge_phase_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MAXT = 440;
  logic              aclk = 1'b0, aresetn = 1'b0, timebase_tick = 1'b0, irq;
  logic [1:0]        tdiv = 2'h0, s_axi_bresp, s_axi_rresp;
  logic              supply_usb_select = 1'b0, usb_power_level_select = 1'b1;
  logic [15:0]       bat_mv = 16'd2800, charge_current_setpoint, rv;
  logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  charge_pkg::phase_t phase_code;
  charge_pkg::led_t   status_pins;
  charge_pkg::comp_t  comp_in;
  logic [33:0]       exp_q[$];
  int                fail_count = 0;
  int                n_compared = 0;

  charge_phase_sequencer #(.MAX_CHARGE_TICKS(MAXT)) i_dut (.aclk, .aresetn, .timebase_tick,
    .comp_in, .supply_usb_select, .usb_power_level_select, .charge_current_setpoint,
    .phase_code, .status_pins, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  charge_partner i_partner (.aclk, .bat_mv, .comp(comp_in));

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    tdiv <= tdiv + 2'h1;
    timebase_tick <= (tdiv == 2'h3);
  end

  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic irq_is(input logic e);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    n_compared++;
    if (irq !== e) begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, irq);
    end
  endtask : irq_is

  // Response and data are compared together, so SLVERR shows up too
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
    // Every write in this bench targets a writable register
    if (s_axi_bvalid && s_axi_bready) begin
      chk({32'h0000_0000, charge_pkg::RESP_OKAY}, {32'h0000_0000, s_axi_bresp});
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = charge_pkg::RESP_OKAY);
    exp_q.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Waits past the comparator synchronisers and the output registers
  task automatic setv(input logic [15:0] v);
    bat_mv <= v;
    repeat (8) @(posedge aclk);
  endtask : setv

  task automatic ticks(input int n);
    repeat (n) @(posedge aclk iff timebase_tick);
  endtask : ticks

  function automatic logic [31:0] st(input logic [2:0] p, input logic [1:0] s,
                                     input logic [1:0] m);
    return {24'h00_0000, m, s, 1'b0, p};
  endfunction : st

  task automatic end_of_test;
    $display("compared %0d, errors %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h8d82));
    rv = 16'($urandom());
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(charge_pkg::OFS_CTRL, 32'h0000_0000);
    rd(charge_pkg::OFS_ADAPTER, {16'h0000, charge_pkg::ADAPTER_RESET});
    rd(charge_pkg::OFS_USB, {16'h0000, charge_pkg::USB_RESET});
    rd(charge_pkg::OFS_STATUS, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000, charge_pkg::RESP_SLVERR);
    wr(charge_pkg::OFS_MASK, 32'h0000_000F);
    wr(charge_pkg::OFS_ADAPTER, {16'h0000, rv});
    rd(charge_pkg::OFS_ADAPTER, {16'h0000, rv});
    // Adapter mode from a deeply discharged battery through a full cycle
    wr(charge_pkg::OFS_CTRL, 32'h0000_0001);
    rd(charge_pkg::OFS_STATUS, st(3'h1, 2'h2, 2'h0));
    rd(charge_pkg::OFS_SETPT, {16'h0000, rv / 16'd10});
    irq_is(1'b0);
    setv(16'd3500);
    rd(charge_pkg::OFS_STATUS, st(3'h2, 2'h2, 2'h0));
    rd(charge_pkg::OFS_SETPT, {16'h0000, rv});
    irq_is(1'b1);
    rd(charge_pkg::OFS_IRQ, 32'h0000_0001);
    irq_is(1'b0);
    setv(16'd4180);
    rd(charge_pkg::OFS_STATUS, st(3'h3, 2'h2, 2'h0));
    setv(16'd4210);
    ticks(6);
    rd(charge_pkg::OFS_STATUS, st(3'h4, 2'h1, 2'h0));
    rd(charge_pkg::OFS_SETPT, 32'h0000_0000);
    rd(charge_pkg::OFS_IRQ, 32'h0000_0002);
    setv(16'd4000);
    rd(charge_pkg::OFS_STATUS, st(3'h2, 2'h2, 2'h0));
    rd(charge_pkg::OFS_IRQ, 32'h0000_0008);
    ticks(420);
    rd(charge_pkg::OFS_STATUS, st(3'h2, 2'h2, 2'h0));
    ticks(25);
    rd(charge_pkg::OFS_STATUS, st(3'h5, 2'h3, 2'h0));
    rd(charge_pkg::OFS_IRQ, 32'h0000_0004);
    wr(charge_pkg::OFS_CTRL, 32'h0000_0000);
    rd(charge_pkg::OFS_STATUS, 32'h0000_0000);
    // Low-power USB: precharge limit stretched five times, then fault
    supply_usb_select <= 1'b1;
    usb_power_level_select <= 1'b0;
    setv(16'd2800);
    wr(charge_pkg::OFS_CTRL, 32'h0000_0001);
    rd(charge_pkg::OFS_STATUS, st(3'h1, 2'h2, 2'h3));
    rd(charge_pkg::OFS_SETPT, 32'h0000_000A);
    ticks(200);
    rd(charge_pkg::OFS_STATUS, st(3'h1, 2'h2, 2'h3));
    ticks(100);
    rd(charge_pkg::OFS_STATUS, st(3'h5, 2'h3, 2'h3));
    rd(charge_pkg::OFS_IRQ, 32'h0000_0004);
    wr(charge_pkg::OFS_CTRL, 32'h0000_0000);
    // High-power USB, charged battery skips precharge; events masked
    wr(charge_pkg::OFS_MASK, 32'h0000_0000);
    usb_power_level_select <= 1'b1;
    setv(16'd3500);
    wr(charge_pkg::OFS_CTRL, 32'h0000_0001);
    rd(charge_pkg::OFS_STATUS, st(3'h2, 2'h2, 2'h1));
    rd(charge_pkg::OFS_SETPT, {16'h0000, charge_pkg::USB_RESET});
    setv(16'd4180);
    setv(16'd4210);
    ticks(6);
    rd(charge_pkg::OFS_STATUS, st(3'h4, 2'h1, 2'h1));
    irq_is(1'b0);
    rd(charge_pkg::OFS_IRQ, 32'h0000_0002);
    rd(charge_pkg::OFS_IRQ, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    end_of_test();
  end
endmodule : charge_phase_sequencer_tb

bind charge_phase_sequencer charge_sequencer_sva #(.MAX_CHARGE_TICKS(MAX_CHARGE_TICKS)) i_sva (
  .aclk, .aresetn, .timebase_tick, .phase_code, .status_pins, .charge_current_setpoint);

// *** tb/charge_sequencer_sva.sv ***
// Checker for the charge phase sequencer, bound to the top module's ports.
// Assumes phase_code and status_pins are both registered from one phase.
module charge_sequencer_sva #(
  parameter int unsigned MAX_CHARGE_TICKS = 32'd440
) (
  input wire logic                         aclk,
  input wire logic                         aresetn,
  input wire logic                         timebase_tick,
  input wire charge_pkg::phase_t           phase_code,
  input wire charge_pkg::led_t             status_pins,
  input wire logic [charge_pkg::CUR_W-1:0] charge_current_setpoint
);
  // Two ticks of slack cover the one-cycle lag of phase_code
  localparam int unsigned PRE_T   = MAX_CHARGE_TICKS / charge_pkg::PRECH_TIME_DIV;
  localparam int unsigned PRE_MAX = PRE_T * charge_pkg::LOW_POWER_DIV + 2;
  localparam int unsigned CHG_MAX = MAX_CHARGE_TICKS * charge_pkg::LOW_POWER_DIV + 2;
  logic [31:0] pre_cnt;
  logic [31:0] chg_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn || phase_code != charge_pkg::PH_PRE) begin
      pre_cnt <= 32'h0000_0000;
    end else if (timebase_tick) begin
      pre_cnt <= pre_cnt + 32'h0000_0001;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !(phase_code inside {charge_pkg::PH_FAST, charge_pkg::PH_VREG})) begin
      chg_cnt <= 32'h0000_0000;
    end else if (timebase_tick) begin
      chg_cnt <= chg_cnt + 32'h0000_0001;
    end
  end
  charge_pins_a: assert property (
    phase_code inside {charge_pkg::PH_PRE, charge_pkg::PH_FAST} && $stable(phase_code)
    |-> status_pins == 2'h2) else $error("status pins wrong while charging");
  done_pins_a: assert property (
    phase_code == charge_pkg::PH_DONE && $stable(phase_code)
    |-> status_pins == 2'h1 && charge_current_setpoint == 16'h0000)
    else $error("done outputs wrong");
  fault_pins_a: assert property (
    phase_code == charge_pkg::PH_FAULT && $stable(phase_code)
    |-> status_pins == 2'h3 && charge_current_setpoint == 16'h0000)
    else $error("fault outputs wrong");
  done_entry_a: assert property (
    $changed(phase_code) && phase_code == charge_pkg::PH_DONE
    |-> $past(phase_code) == charge_pkg::PH_VREG) else $error("done entered from bad phase");
  recharge_exit_a: assert property (
    $past(phase_code) == charge_pkg::PH_DONE && phase_code != charge_pkg::PH_DONE
    |-> phase_code inside {charge_pkg::PH_FAST, charge_pkg::PH_IDLE})
    else $error("bad exit from done");
  pre_exit_a: assert property (
    $past(phase_code) == charge_pkg::PH_PRE && phase_code != charge_pkg::PH_PRE
    |-> phase_code != charge_pkg::PH_VREG && phase_code != charge_pkg::PH_DONE)
    else $error("bad exit from precharge");
  pre_early_a: assert property (
    $changed(phase_code) && phase_code == charge_pkg::PH_FAULT
    && $past(phase_code) == charge_pkg::PH_PRE |-> $past(pre_cnt) >= PRE_T - 2)
    else $error("precharge fault too early");
  pre_late_a: assert property (pre_cnt <= PRE_MAX)
    else $error("precharge ran past its limit");
  chg_early_a: assert property (
    $changed(phase_code) && phase_code == charge_pkg::PH_FAULT
    && $past(phase_code) != charge_pkg::PH_PRE |-> $past(chg_cnt) >= MAX_CHARGE_TICKS - 2)
    else $error("charge fault too early");
  chg_late_a: assert property (chg_cnt <= CHG_MAX)
    else $error("charge ran past its limit");
endmodule : charge_sequencer_sva
